// [inc/csc_pkg.sv]
// Constants shared by the clock synthesizer control block.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
package csc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] IEN_OFS = 8'h08;
    localparam logic [7:0] ICLR_OFS = 8'h0c;
    localparam logic [7:0] INFO_OFS = 8'h10;
    // Control register layout and reset value
    localparam logic [15:0] CTRL_RST = 16'h3f00;
    localparam int W_BIT = 15;
    localparam int X_BIT = 14;
    localparam int Y_MSB = 13;
    localparam int Y_LSB = 8;
    localparam int LOCK_BIT = 3;
    localparam int Y_W = 6;
    // Interrupt event bits
    localparam int EV_W = 2;
    localparam int EV_LOCK = 0;
    localparam int EV_LOSS = 1;
    localparam logic [1:0] EV_RST = 2'h0;
    // Info register bits
    localparam int INFO_PLL_BIT = 0;
    localparam int INFO_RUN_BIT = 1;
    // Relock model: reference edges until lock
    localparam int LOCK_REF_CYCLES = 64;
    localparam int LOCK_CNT_W = 16;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Internal reset sequencer states
    typedef enum logic [1:0]
    {
        ST_HOLD = 2'h1,
        ST_RUN = 2'h2
    } csc_rst_e;
endpackage : csc_pkg

// [logic/csc_lock_model.sv]
// Behavioural lock model of the frequency synthesizer loop.
// Assumes ref_tick is a one-cycle pulse per reference edge.
`timescale 1ns/1ns
`default_nettype none
module csc_lock_model
    import csc_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_REF_CYCLES,
    parameter int CNT_W = LOCK_CNT_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic relock,
    input wire logic ref_tick,
    output logic locked
);
    // Reference edges still to wait before lock
    logic [CNT_W-1:0] remain;
    // Loop settles once the count runs out on a reference edge
    wire done = (remain == CNT_W'(1)) && ref_tick;

    // Any relock request restarts the wait and drops lock at once
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            remain <= CNT_W'(LOCK_CYCLES);
            locked <= 1'b0;
        end
        else if (!enable)
        begin
            // Synthesizer off: it never claims lock
            remain <= CNT_W'(LOCK_CYCLES);
            locked <= 1'b0;
        end
        else if (relock)
        begin
            remain <= CNT_W'(LOCK_CYCLES);
            locked <= 1'b0;
        end
        else if (done)
        begin
            remain <= '0;
            locked <= 1'b1;
        end
        else if (ref_tick && remain != '0)
        begin
            remain <= remain - CNT_W'(1);
        end
    end
endmodule : csc_lock_model
`default_nettype wire

// [logic/csc_top.sv]
// Clock source selection and synthesizer control with AXI4-Lite registers.
// Assumes all inputs are synchronous to aclk; ref_clock_in is sampled.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Mode pin high at reset selects synthesizer
// - Mode pin low: synthesizer off, controls ignored
// - Oscillator runs two or four times system
// - Read-only lock bit shows synthesizer lock
// - Comparator input change forces loss and relock
// - Internal reset held until first lock in synthesizer mode
// - Prescale bit raises oscillator four times
// - Modulus field divides feedback by value+1
// - Prescale or modulus change starts relock
// - Halving-disable resets zero, doubles when set
// - Halving-disable change acts without relock
// - System = ref x 4(Y+1) x 2^(2W+X)
// - Control register resets to 16'h3f00
module csc_top
    import csc_pkg::*;
#(
    parameter int AW = 8,
    parameter int LOCK_CYCLES = LOCK_REF_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_mode_select_pin,
    input wire logic ref_clock_in,
    input wire logic ref_disturb,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic synth_enable,
    output logic [11:0] sys_mult,
    output logic [13:0] vco_mult,
    output logic sys_reset_n,
    output logic irq
);
    // Held write address and data while the other half is awaited
    logic aw_full;
    logic w_full;
    logic [AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // Control fields
    logic fb_prescale; // Feedback prescale select
    logic halve_off; // Output halving disable
    logic [Y_W-1:0] loop_modulus;
    // Interrupt state
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    // Reference edge detect and lock history
    logic ref_q;
    logic lock_q;
    logic pll_locked;
    csc_rst_e rst_state;

    // Handshakes on each channel
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire b_hs = s_axi_bvalid && s_axi_bready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    // Write goes ahead once both halves are in hand
    wire aw_have = aw_full || aw_hs;
    wire w_have = w_full || w_hs;
    wire do_wr = aw_have && w_have && !s_axi_bvalid;
    wire [AW-1:0] wr_addr = aw_full ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_full ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_full ? w_strb : s_axi_wstrb;
    // Only the low byte of the address selects; upper bits must be zero
    wire wr_hi_zero = (wr_addr >> 8) == '0;
    wire [7:0] wr_ofs = wr_addr[7:0];
    wire wr_ctrl = do_wr && wr_hi_zero && wr_ofs == CTRL_OFS;
    wire wr_ien = do_wr && wr_hi_zero && wr_ofs == IEN_OFS;
    wire wr_iclr = do_wr && wr_hi_zero && wr_ofs == ICLR_OFS;
    wire wr_ro = do_wr && wr_hi_zero && (wr_ofs == STAT_OFS || wr_ofs == INFO_OFS);
    wire wr_ok = wr_ctrl || wr_ien || wr_iclr || wr_ro;

    // Byte lane 1 carries every writable control bit
    wire ctrl_lane = wr_ctrl && wr_strb[1];
    wire new_w = wr_data[W_BIT];
    wire new_x = wr_data[X_BIT];
    wire [Y_W-1:0] new_y = wr_data[Y_MSB:Y_LSB];
    // Only the feedback path needs to relock; X sits outside the loop
    wire fb_change = ctrl_lane && (new_w != fb_prescale || new_y != loop_modulus);
    // Mode latched at reset; in external mode nothing reaches the loop
    logic pll_mode;
    wire relock = pll_mode && (fb_change || ref_disturb);

    // Reference rising edge, one cycle pulse
    wire ref_tick = ref_clock_in && !ref_q;

    // Multiplier: 4(Y+1) shifted by 2W+X, which is {W,X} as a number
    wire [6:0] mod_p1 = {1'b0, loop_modulus} + 7'h01;
    wire [11:0] mod_x4 = {3'h0, mod_p1, 2'h0};
    wire [1:0] pre_shift = {fb_prescale, halve_off};
    wire [11:0] next_sys_mult = mod_x4 << pre_shift;
    // Oscillator keeps 50% duty: four times with halving, else two
    wire [13:0] sys_wide = {2'h0, next_sys_mult};
    wire [13:0] next_vco_mult = halve_off ? (sys_wide << 1) : (sys_wide << 2);

    // Lock events for the interrupt status
    wire ev_lock = pll_locked && !lock_q;
    wire ev_loss = !pll_locked && lock_q;
    wire [EV_W-1:0] ev_set = {ev_loss, ev_lock};
    wire [EV_W-1:0] clr_bits = wr_iclr ? wr_data[EV_W-1:0] : EV_RST;
    // Set beats clear so an event in the clear cycle survives
    wire [EV_W-1:0] next_status = (irq_status & ~clr_bits) | ev_set;

    // Read decode
    wire rd_hi_zero = (s_axi_araddr >> 8) == '0;
    wire [7:0] rd_ofs = s_axi_araddr[7:0];
    wire [15:0] ctrl_view = {fb_prescale, halve_off, loop_modulus, 4'h0, pll_locked, 3'h0};
    wire rd_ctrl = rd_hi_zero && rd_ofs == CTRL_OFS;
    wire rd_stat = rd_hi_zero && rd_ofs == STAT_OFS;
    wire rd_ien = rd_hi_zero && rd_ofs == IEN_OFS;
    wire rd_iclr = rd_hi_zero && rd_ofs == ICLR_OFS;
    wire rd_info = rd_hi_zero && rd_ofs == INFO_OFS;
    wire rd_ok = rd_ctrl || rd_stat || rd_ien || rd_iclr || rd_info;
    wire [31:0] info_view = 32'({sys_reset_n, pll_mode});
    // Clear register is write-only and reads as zero
    wire [31:0] next_rdata =
        rd_ctrl ? {16'h0, ctrl_view} :
        rd_stat ? 32'(irq_status) :
        rd_ien ? 32'(irq_enable) :
        rd_info ? info_view : 32'h0;

    // Mode pin caught by a clocked process while reset is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pll_mode <= clock_mode_select_pin;
        end
    end

    // Loop lock model, runs on reference edges
    csc_lock_model #(
        .LOCK_CYCLES(LOCK_CYCLES),
        .CNT_W(LOCK_CNT_W)
    ) u_lock (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(pll_mode),
        .relock(relock),
        .ref_tick(ref_tick),
        .locked(pll_locked)
    );

    // Write channel: ready falls on take, returns after response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                s_axi_awready <= 1'b0;
                aw_full <= !do_wr;
            end
            if (w_hs)
            begin
                s_axi_wready <= 1'b0;
                w_full <= !do_wr;
            end
            if (do_wr)
            begin
                // Both halves consumed here; flags drop
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (b_hs)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Captured write payload
    always_ff @(posedge aclk)
    begin
        if (aw_hs)
        begin
            aw_addr <= s_axi_awaddr;
        end
        if (w_hs)
        begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Control fields; the lock bit has no storage so writes to it vanish
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fb_prescale <= CTRL_RST[W_BIT];
            halve_off <= CTRL_RST[X_BIT];
            loop_modulus <= CTRL_RST[Y_MSB:Y_LSB];
        end
        else if (ctrl_lane)
        begin
            fb_prescale <= new_w;
            halve_off <= new_x;
            loop_modulus <= new_y;
        end
    end

    // Interrupt status, enable and level output
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= EV_RST;
            irq_enable <= EV_RST;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= next_status;
            if (wr_ien && wr_strb[0])
            begin
                irq_enable <= wr_data[EV_W-1:0];
            end
            irq <= |(next_status & irq_enable);
        end
    end

    // Edge and lock history
    always_ff @(posedge aclk)
    begin
        // Reference tracked through reset so no false edge follows release
        ref_q <= ref_clock_in;
        if (!aresetn)
        begin
            lock_q <= 1'b0;
        end
        else
        begin
            lock_q <= pll_locked;
        end
    end

    // Internal reset: synthesizer mode waits for first lock only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_state <= ST_HOLD;
            sys_reset_n <= 1'b0;
        end
        else
        begin
            unique case (rst_state)
                ST_HOLD:
                begin
                    // External clock needs no lock wait
                    if (!pll_mode || pll_locked)
                    begin
                        rst_state <= ST_RUN;
                        sys_reset_n <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    // Later relocks do not reassert reset
                    sys_reset_n <= 1'b1;
                end
                default:
                begin
                    rst_state <= ST_HOLD;
                    sys_reset_n <= 1'b0;
                end
            endcase
        end
    end

    // Frequency outputs follow X at once; zero in external mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            synth_enable <= 1'b0;
            sys_mult <= 12'h0;
            vco_mult <= 14'h0;
        end
        else
        begin
            synth_enable <= pll_mode;
            sys_mult <= pll_mode ? next_sys_mult : 12'h0;
            vco_mult <= pll_mode ? next_vco_mult : 14'h0;
        end
    end
endmodule : csc_top
`default_nettype wire

// [sim/csc_top_assertions.sv]
// Port-level checks for the clock synthesizer control block.
// Assumes it is bound into csc_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module csc_checker
    import csc_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_REF_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_mode_select_pin,
    input wire logic ref_clock_in,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic synth_enable,
    input wire logic [11:0] sys_mult,
    input wire logic [13:0] vco_mult,
    input wire logic sys_reset_n,
    input wire logic irq
);
    // Strap level as last seen in reset
    logic mode_q;
    // Previous reference level
    logic ref_q;
    // Reference edges since release, saturating so it never wraps
    logic [7:0] ref_cnt;

    // Capture the strap in reset and count reference edges after it
    always_ff @(posedge aclk)
    begin
        ref_q <= ref_clock_in;
        if (!aresetn)
        begin
            mode_q <= clock_mode_select_pin;
            ref_cnt <= 8'h00;
        end
        else if (ref_clock_in && !ref_q && ref_cnt != 8'hff)
        begin
            ref_cnt <= ref_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Reset itself is watched here, so the default disable is overridden
    rst_quiet_a:
    assert property (disable iff (1'b0) !aresetn |=> !sys_reset_n && !irq && !s_axi_rvalid)
        else $error("outputs not quiet in reset");
    mode_pick_a:
    assert property ($past(aresetn) |-> synth_enable == mode_q)
        else $error("clock source differs from strap");
    ext_off_a:
    assert property (!synth_enable |-> sys_mult == 12'h000 && vco_mult == 14'h0000)
        else $error("external mode drives multipliers");
    vco_ratio_a:
    assert property (synth_enable |-> vco_mult == {sys_mult, 2'b00} || vco_mult == {1'b0, sys_mult, 1'b0})
        else $error("oscillator not two or four times system");
    mult_hold_a:
    assert property ($past(synth_enable) && !s_axi_bvalid && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) |-> $stable(sys_mult))
        else $error("system multiplier moved without a write");
    lock_wait_a:
    assert property ($rose(sys_reset_n) && synth_enable |-> ref_cnt >= LOCK_CYCLES)
        else $error("internal reset left before lock");
    rst_hold_a:
    assert property (sys_reset_n |=> sys_reset_n)
        else $error("internal reset asserted again");
    rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    wr_answer_a:
    assert property (s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
endmodule : csc_checker

bind csc_top csc_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_csc_checker (.aclk(aclk),
    .aresetn(aresetn), .clock_mode_select_pin(clock_mode_select_pin),
    .ref_clock_in(ref_clock_in), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .synth_enable(synth_enable),
    .sys_mult(sys_mult), .vco_mult(vco_mult), .sys_reset_n(sys_reset_n), .irq(irq));
`default_nettype wire

// [sim/csc_ref_model.sv]
// Reference clock source standing at the far side of the block.
// Assumes the bench clock; the reference runs free like a crystal.
`timescale 1ns/1ns
`default_nettype none
module csc_ref_model
#(
    parameter int HALF = 4
)
(
    input wire logic aclk,
    input wire logic disturb_req,
    output logic ref_clock_in,
    output logic ref_disturb
);
    // Half-period counter, reference level and disturbance pulse
    int cnt = 0;
    logic ref_q = 1'b0;
    logic dist_q = 1'b0;

    // Toggle every HALF cycles; a request gives one disturbance pulse
    always @(posedge aclk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
        begin
            ref_q <= !ref_q;
        end
        dist_q <= disturb_req;
    end
    assign ref_clock_in = ref_q;
    assign ref_disturb = dist_q;
endmodule : csc_ref_model
`default_nettype wire

// [sim/csc_top_tb_top.sv]
// Self-checking bench for the clock synthesizer control block.
// Assumes csc_top, its checker and the reference model are compiled.
`timescale 1ns/1ns
`default_nettype none
module csc_top_tb_top
    import csc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic mode = 1'b1;
    logic disturb_req = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic ref_clk, ref_dist, awready, wready, bvalid, arready, rvalid, synth_enable;
    logic sys_reset_n, irq;
    logic [1:0] bresp, rresp, rrsp;
    logic [31:0] rdata, rdat, cw;
    logic [11:0] sys_mult, es;
    logic [13:0] vco_mult;
    int failures = 0;
    int n_compared = 0;

    always #10 aclk = ~aclk;

    csc_ref_model #(.HALF(4)) u_ref (.aclk(aclk), .disturb_req(disturb_req),
        .ref_clock_in(ref_clk), .ref_disturb(ref_dist));

    // Short lock count keeps relock waits brief
    csc_top #(.AW(8), .LOCK_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn),
        .clock_mode_select_pin(mode), .ref_clock_in(ref_clk), .ref_disturb(ref_dist),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .synth_enable(synth_enable),
        .sys_mult(sys_mult), .vco_mult(vco_mult), .sys_reset_n(sys_reset_n), .irq(irq));

    // Compare a seen value with its expectation
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Write: both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ah;
        logic wh;
        ah = 1'b0;
        wh = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ah && wh))
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            ah = ah | awready;
            wh = wh | wready;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr

    // Read: result left in rdat and rrsp; rready is held high throughout
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rdat = rdata;
        rrsp = rresp;
    endtask : rd

    // Read one register and compare data and response
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a);
        chk("rdata", rdat, e);
        chk("rresp", {30'h0, rrsp}, {30'h0, er});
    endtask : rc

    // Poll control until the lock bit reads set; the watchdog bounds it
    task automatic lockwait();
        do rd(CTRL_OFS); while (rdat[LOCK_BIT] !== 1'b1);
    endtask : lockwait

    // Verdict and end of run
    task automatic end_sim();
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // A run takes well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc(CTRL_OFS, 32'h3f00, RESP_OKAY);
        chk("sys_mult", sys_mult, 32'h100);
        chk("vco_mult", vco_mult, 32'h400);
        chk("synth_enable", synth_enable, 32'h1);
        chk("sys_reset_n", sys_reset_n, 32'h0);
        lockwait();
        @(posedge aclk);
        chk("sys_reset_n", sys_reset_n, 32'h1);
        rc(STAT_OFS, 32'h1, RESP_OKAY);
        chk("irq", irq, 32'h0);
        wr(IEN_OFS, 32'h3, 4'hf, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq", irq, 32'h1);
        wr(ICLR_OFS, 32'h1, 4'hf, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq", irq, 32'h0);
        wr(CTRL_OFS, 32'h7f00, 4'hf, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("sys_mult", sys_mult, 32'h200);
        chk("vco_mult", vco_mult, 32'h400);
        rc(CTRL_OFS, 32'h7f08, RESP_OKAY);
        // Every prescale pair with moduli across the range, kept legal
        for (int i = 0; i < 8; i++)
        begin
            cw = {16'h0, i[1], i[0], 6'(i * 9), 8'h00};
            es = 12'(4 * (i * 9 + 1)) << (2 * i[1] + i[0]);
            wr(CTRL_OFS, cw, 4'h2, RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("sys_mult", sys_mult, 32'(es));
            chk("vco_mult", vco_mult, 32'(es) << (i[0] ? 1 : 2));
        end
        rc(CTRL_OFS, 32'hff00, RESP_OKAY);
        rc(STAT_OFS, 32'h2, RESP_OKAY);
        chk("irq", irq, 32'h1);
        lockwait();
        wr(CTRL_OFS, 32'h0008, 4'h1, RESP_OKAY);
        wr(STAT_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rc(CTRL_OFS, 32'hff08, RESP_OKAY);
        rc(STAT_OFS, 32'h3, RESP_OKAY);
        wr(8'h40, 32'h1, 4'hf, RESP_SLVERR);
        rc(8'h40, 32'h0, RESP_SLVERR);
        disturb_req <= 1'b1;
        @(posedge aclk);
        disturb_req <= 1'b0;
        repeat (3) @(posedge aclk);
        rc(CTRL_OFS, 32'hff00, RESP_OKAY);
        lockwait();
        // Second reset with the strap low selects the external clock
        aresetn <= 1'b0;
        mode <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        wr(CTRL_OFS, 32'h0100, 4'hf, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("synth_enable", synth_enable, 32'h0);
        chk("sys_mult", sys_mult, 32'h0);
        chk("vco_mult", vco_mult, 32'h0);
        rc(CTRL_OFS, 32'h0100, RESP_OKAY);
        rc(INFO_OFS, 32'h2, RESP_OKAY);
        end_sim();
    end
endmodule : csc_top_tb_top
`default_nettype wire
